// ---- include/naotm_pkg.sv ----
// Constants, types and register map of the normalize and OR-to-memory datapath.
//
// Notes on behaviour
// - Index register update of the shift step happens in execution, not address generation.
// - One shift step is one word, one cycle on-chip, one plus waits external.
// - Repeated n times it takes n cycles, or n plus waits when external.
// - Once the magnitude bit is found, remaining repeat iterations do nothing.
// - Plain indirect form leaves the current index register unchanged.
// - Mask form ORs memory word with bit mask register; one word, PC plus one.
// - Constant form ORs memory word with the 16-bit inline constant; PC plus two.
// - OR result returns to the same address; the sum register is untouched.
// - After OR, test flag is set when the result is zero, else cleared.
// - Shift step: bits 31 and 30 equal shifts left, clears flag, modifies index.
// - A zero sum register makes the shift step set the flag without shifting.
// - Default index modification of the shift step is an increment by one.
package naotm_pkg;
	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int DW        = 16;
	localparam int ACC_W     = 32;
	localparam int BUS_AW    = 8;
	localparam int BUS_DW    = 32;
	localparam int NUM_IDX   = 8;
	localparam int IDX_W     = 3;
	localparam int MEM_WORDS = 16;
	localparam int MEM_IW    = 4;
	localparam int RPT_W     = 8;
	localparam int CNT_W     = 10;
	// ------------------------------------------------------------------
	// Register map and field positions
	// ------------------------------------------------------------------
	localparam logic [BUS_AW-1:0] OFS_PTR  = 8'h00;
	localparam logic [BUS_AW-1:0] OFS_MASK = 8'h04;
	localparam logic [BUS_AW-1:0] OFS_ACC  = 8'h08;
	localparam logic [BUS_AW-1:0] OFS_STAT = 8'h0C;
	localparam logic [BUS_AW-1:0] OFS_CYC  = 8'h10;
	localparam int                WORD_LSB = 2;
	localparam int                IDX_RMSB = 7;
	localparam int                IDX_RLSB = 5;
	localparam logic [2:0]        IDX_REGION = 3'h1;
	localparam int                MEM_RMSB = 7;
	localparam int                MEM_RLSB = 6;
	localparam logic [1:0]        MEM_REGION = 2'h1;
	localparam int                STAT_TC_BIT   = 0;
	localparam int                STAT_BUSY_BIT = 1;
	localparam int                STAT_STOP_BIT = 2;
	localparam int                ACC_SIGN = 31;
	localparam int                ACC_NEXT = 30;
	// ------------------------------------------------------------------
	// Reset values and cycle figures
	// ------------------------------------------------------------------
	localparam logic [ACC_W-1:0]  RST_ACC  = 32'h0000_0000;
	localparam logic [DW-1:0]     RST_WORD = 16'h0000;
	localparam logic [IDX_W-1:0]  RST_PTR  = 3'h0;
	localparam logic [CNT_W-1:0]  RUN_MASK  = 10'h001;
	localparam logic [CNT_W-1:0]  RUN_CONST = 10'h002;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 10'h001;
	localparam logic [CNT_W-1:0]  CNT_ZERO  = 10'h000;
	localparam logic [1:0]        STEP_ONE  = 2'h1;
	localparam logic [1:0]        STEP_TWO  = 2'h2;
	localparam logic [1:0]        STEP_NONE = 2'h0;
	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_SIGN_SHIFT_STEP     = 2'b00,
		OP_OR_MASK  = 2'b01,
		OP_OR_CONST = 2'b10
	} naotm_op_t;
	typedef enum logic [1:0] {
		IND_INC   = 2'b00,
		IND_PLAIN = 2'b01,
		IND_DEC   = 2'b10
	} naotm_ind_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN  = 2'b10
	} naotm_state_t;
endpackage

// ---- hdl/naotm_alu.sv ----
// Combinational shift-step test and bitwise memory unit.
`timescale 1ns/10ps
module naotm_alu
	import naotm_pkg::*;
(
	input  wire logic [ACC_W-1:0] main_sum_register,
	input  wire logic [DW-1:0]    mem_word,
	input  wire logic [DW-1:0]    bit_mask_register,
	input  wire logic [DW-1:0]    inline_constant,
	input  wire logic             use_const,
	output logic                  sign_shift_step_shift,
	output logic [ACC_W-1:0]      sign_shift_step_acc,
	output logic [DW-1:0]         or_res,
	output logic                  or_zero
);
	// ------------------------------------------------------------------
	// Shift step
	// ------------------------------------------------------------------
	always_comb begin
		sign_shift_step_shift = (main_sum_register != RST_ACC) &&
			(main_sum_register[ACC_SIGN] == main_sum_register[ACC_NEXT]);
		sign_shift_step_acc   = {main_sum_register[ACC_W-2:0], 1'b0};
	end
	// ------------------------------------------------------------------
	// OR with mask or inline constant
	// ------------------------------------------------------------------
	always_comb begin
		or_res  = mem_word | (use_const ? inline_constant : bit_mask_register);
		or_zero = (or_res == RST_WORD);
	end
endmodule

// ---- hdl/naotm_core.sv ----
// Sequencer and register file of the normalize and OR-to-memory datapath.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module naotm_core
	import naotm_pkg::*;
#(
	parameter int PROG_WAIT = 1
)
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [BUS_AW-1:0] bus_addr,
	input  wire logic [BUS_DW-1:0] bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic [BUS_DW-1:0]      bus_rdata,
	input  wire logic              ins_valid,
	input  wire logic [1:0]        ins_op,
	input  wire logic [1:0]        ins_mode,
	input  wire logic              ins_indirect,
	input  wire logic [DW-1:0]     ins_dma,
	input  wire logic [DW-1:0]     ins_const,
	input  wire logic              ins_ext,
	input  wire logic [RPT_W-1:0]  ins_rpt,
	output logic                   ins_ready,
	output logic                   ins_done,
	output logic [1:0]             pc_step,
	output logic                   test_flag
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	naotm_state_t      state;
	naotm_op_t         cur_op;
	naotm_ind_t        cur_mode;
	logic              cur_ind;
	logic [IDX_W-1:0]  cur_ptr;
	logic [MEM_IW-1:0] op_addr;
	logic [DW-1:0]     cur_const;
	logic              sign_shift_step_stop;
	logic [CNT_W-1:0]  wait_cnt;
	logic [CNT_W-1:0]  run_cnt;
	logic [CNT_W-1:0]  busy_cnt;
	logic [CNT_W-1:0]  last_cycles;
	logic [ACC_W-1:0]  main_sum_register;
	logic [DW-1:0]     bit_mask_register;
	logic [IDX_W-1:0]  pointer_select;
	logic [DW-1:0]     indexing_register [NUM_IDX];
	logic [DW-1:0]     data_mem [MEM_WORDS];
	logic              accept;
	logic              last_run;
	logic              sign_shift_step_exec;
	logic              or_exec;
	logic              ar_mod;
	logic [DW-1:0]     ar_delta;
	logic [CNT_W-1:0]  next_run;
	logic [CNT_W-1:0]  next_wait;
	logic [CNT_W-1:0]  prog_wait;
	logic              sign_shift_step_shift;
	logic [ACC_W-1:0]  sign_shift_step_acc;
	logic [DW-1:0]     or_res;
	logic              or_zero;
	logic              hit_idx;
	logic              hit_mem;
	logic [IDX_W-1:0]  bus_idx;
	logic [MEM_IW-1:0] bus_mem;

	// ------------------------------------------------------------------
	// Issue and cycle accounting
	// ------------------------------------------------------------------
	assign accept    = ins_valid && ins_ready;
	assign prog_wait = CNT_W'(PROG_WAIT);
	assign last_run  = (state == ST_RUN) && (run_cnt == CNT_ONE);
	assign sign_shift_step_exec = (state == ST_RUN) && (cur_op == OP_SIGN_SHIFT_STEP) && !sign_shift_step_stop;
	assign or_exec   = last_run && (cur_op != OP_SIGN_SHIFT_STEP);

	always_comb begin
		unique case (naotm_op_t'(ins_op))
			OP_OR_MASK:  next_run = RUN_MASK;
			OP_OR_CONST: next_run = RUN_CONST;
			default:     next_run = (ins_rpt == '0) ? CNT_ONE : CNT_W'(ins_rpt);
		endcase
		if (!ins_ext) begin
			next_wait = CNT_ZERO;
		end else if (naotm_op_t'(ins_op) == OP_OR_CONST) begin
			next_wait = CNT_W'(prog_wait + prog_wait);
		end else begin
			next_wait = prog_wait;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			wait_cnt <= CNT_ZERO;
			run_cnt  <= CNT_ZERO;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (accept) begin
						wait_cnt <= next_wait;
						run_cnt  <= next_run;
						state    <= (next_wait != CNT_ZERO) ? ST_WAIT : ST_RUN;
					end
				end
				ST_WAIT: begin
					wait_cnt <= CNT_W'(wait_cnt - CNT_ONE);
					if (wait_cnt == CNT_ONE) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					run_cnt <= CNT_W'(run_cnt - CNT_ONE);
					if (run_cnt == CNT_ONE) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_op    <= OP_SIGN_SHIFT_STEP;
			cur_mode  <= IND_INC;
			cur_ind   <= 1'b0;
			cur_ptr   <= RST_PTR;
			op_addr   <= '0;
			cur_const <= RST_WORD;
		end else if (accept) begin
			cur_op    <= naotm_op_t'(ins_op);
			cur_mode  <= naotm_ind_t'(ins_mode);
			cur_ind   <= ins_indirect;
			cur_ptr   <= pointer_select;
			cur_const <= ins_const;
			op_addr   <= ins_indirect ? indexing_register[pointer_select][MEM_IW-1:0]
				: ins_dma[MEM_IW-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ins_ready <= 1'b1;
			ins_done  <= 1'b0;
			pc_step   <= STEP_NONE;
		end else begin
			ins_done <= last_run;
			if (accept) begin
				ins_ready <= 1'b0;
			end else if (last_run) begin
				ins_ready <= 1'b1;
			end
			if (last_run) begin
				pc_step <= (cur_op == OP_OR_CONST) ? STEP_TWO : STEP_ONE;
			end else begin
				pc_step <= STEP_NONE;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt    <= CNT_ZERO;
			last_cycles <= CNT_ZERO;
		end else begin
			if (accept) begin
				busy_cnt <= CNT_ONE;
			end else if (!ins_ready) begin
				busy_cnt <= CNT_W'(busy_cnt + CNT_ONE);
			end
			if (last_run) begin
				last_cycles <= busy_cnt;
			end
		end
	end

	// ------------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------------
	naotm_alu u_alu (
		.main_sum_register (main_sum_register),
		.mem_word          (data_mem[op_addr]),
		.bit_mask_register (bit_mask_register),
		.inline_constant   (cur_const),
		.use_const         (cur_op == OP_OR_CONST),
		.sign_shift_step_shift        (sign_shift_step_shift),
		.sign_shift_step_acc          (sign_shift_step_acc),
		.or_res            (or_res),
		.or_zero           (or_zero)
	);

	// Clearing the stop mark on issue gives each repeat block a fresh search.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sign_shift_step_stop <= 1'b0;
		end else if (accept) begin
			sign_shift_step_stop <= 1'b0;
		end else if (sign_shift_step_exec && !sign_shift_step_shift) begin
			sign_shift_step_stop <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			test_flag <= 1'b0;
		end else if (sign_shift_step_exec) begin
			test_flag <= !sign_shift_step_shift;
		end else if (or_exec) begin
			test_flag <= or_zero;
		end
	end

	// The execution path wins over a software write in the same cycle.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			main_sum_register <= RST_ACC;
		end else if (sign_shift_step_exec && sign_shift_step_shift) begin
			main_sum_register <= sign_shift_step_acc;
		end else if (bus_wr && bus_addr == OFS_ACC) begin
			main_sum_register <= bus_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_mask_register <= RST_WORD;
			pointer_select    <= RST_PTR;
		end else if (bus_wr) begin
			if (bus_addr == OFS_MASK) begin
				bit_mask_register <= bus_wdata[DW-1:0];
			end
			if (bus_addr == OFS_PTR) begin
				pointer_select <= bus_wdata[IDX_W-1:0];
			end
		end
	end

	// Index register modification happens only in the run state, never at issue; bus writes can land in any state.
	assign ar_mod   = ((sign_shift_step_exec && sign_shift_step_shift) || (or_exec && cur_ind)) &&
		(cur_mode != IND_PLAIN);
	assign ar_delta = (cur_mode == IND_DEC) ? {DW{1'b1}} : {{(DW-1){1'b0}}, 1'b1};
	assign hit_idx  = bus_addr[IDX_RMSB:IDX_RLSB] == IDX_REGION;
	assign hit_mem  = bus_addr[MEM_RMSB:MEM_RLSB] == MEM_REGION;
	assign bus_idx  = bus_addr[WORD_LSB+IDX_W-1:WORD_LSB];
	assign bus_mem  = bus_addr[WORD_LSB+MEM_IW-1:WORD_LSB];

	generate
		for (genvar i = 0; i < NUM_IDX; i++) begin : g_idx
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					indexing_register[i] <= RST_WORD;
				end else if (ar_mod && cur_ptr == IDX_W'(i)) begin
					indexing_register[i] <= DW'(indexing_register[i] + ar_delta);
				end else if (bus_wr && hit_idx && bus_idx == IDX_W'(i)) begin
					indexing_register[i] <= bus_wdata[DW-1:0];
				end
			end
		end
		for (genvar j = 0; j < MEM_WORDS; j++) begin : g_mem
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					data_mem[j] <= RST_WORD;
				end else if (or_exec && op_addr == MEM_IW'(j)) begin
					data_mem[j] <= or_res;
				end else if (bus_wr && hit_mem && bus_mem == MEM_IW'(j)) begin
					data_mem[j] <= bus_wdata[DW-1:0];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= '0;
		end else if (bus_rd) begin
			bus_rdata <= '0;
			if (bus_addr == OFS_PTR) begin
				bus_rdata[IDX_W-1:0] <= pointer_select;
			end else if (bus_addr == OFS_MASK) begin
				bus_rdata[DW-1:0] <= bit_mask_register;
			end else if (bus_addr == OFS_ACC) begin
				bus_rdata <= main_sum_register;
			end else if (bus_addr == OFS_STAT) begin
				bus_rdata[STAT_TC_BIT]   <= test_flag;
				bus_rdata[STAT_BUSY_BIT] <= !ins_ready;
				bus_rdata[STAT_STOP_BIT] <= sign_shift_step_stop;
			end else if (bus_addr == OFS_CYC) begin
				bus_rdata[CNT_W-1:0] <= last_cycles;
			end else if (hit_idx) begin
				bus_rdata[DW-1:0] <= indexing_register[bus_idx];
			end else if (hit_mem) begin
				bus_rdata[DW-1:0] <= data_mem[bus_mem];
			end
		end else begin
			bus_rdata <= '0;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [CNT_W-1:0] exp_cycles;
	logic [CNT_W-1:0] obs_cycles;
	logic [DW-1:0]    cur_ar;
	assign cur_ar = indexing_register[cur_ptr];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			exp_cycles <= CNT_ZERO;
			obs_cycles <= CNT_ZERO;
		end else if (accept) begin
			exp_cycles <= CNT_W'(next_run + next_wait);
			obs_cycles <= CNT_ONE;
		end else if (!ins_ready) begin
			obs_cycles <= CNT_W'(obs_cycles + CNT_ONE);
		end
	end

	sequence s_shift_iter;
		sign_shift_step_exec && sign_shift_step_shift && !bus_wr;
	endsequence

	sequence s_found_iter;
		(state == ST_RUN) && (cur_op == OP_SIGN_SHIFT_STEP) && sign_shift_step_stop && !bus_wr;
	endsequence

	AST_AR_IN_EXEC: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state != ST_RUN && !bus_wr) |=> $stable(cur_ar) || $changed(cur_ptr))
		else $error("Index register moved outside the execution phase.");

	AST_SIGN_SHIFT_STEP_SINGLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(last_run && cur_op == OP_SIGN_SHIFT_STEP) |-> obs_cycles == exp_cycles)
		else $error("Shift step cycle count is wrong.");

	AST_SIGN_SHIFT_STEP_REPEAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(accept && naotm_op_t'(ins_op) == OP_SIGN_SHIFT_STEP && !ins_ext && ins_rpt == 8'h03)
		|=> !ins_ready [*3] ##1 ins_ready)
		else $error("Repeated shift step did not take n cycles.");

	AST_NOP_AFTER_FOUND: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_found_iter |=> $stable(main_sum_register) && test_flag && $stable(cur_ar))
		else $error("Shift step acted after the magnitude bit was found.");

	AST_PLAIN_KEEPS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_RUN && cur_mode == IND_PLAIN && !bus_wr) |=> $stable(cur_ar))
		else $error("Plain indirect form modified the index register.");

	AST_OR_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(or_exec && cur_op == OP_OR_MASK && !bus_wr)
		|=> data_mem[$past(op_addr)] == ($past(data_mem[op_addr]) | $past(bit_mask_register))
		&& pc_step == STEP_ONE)
		else $error("Mask form result or program step is wrong.");

	AST_OR_CONST: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(or_exec && cur_op == OP_OR_CONST && !bus_wr)
		|=> data_mem[$past(op_addr)] == ($past(data_mem[op_addr]) | $past(cur_const))
		&& pc_step == STEP_TWO)
		else $error("Constant form result or program step is wrong.");

	AST_ACC_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_RUN && cur_op != OP_SIGN_SHIFT_STEP && !bus_wr) |=> $stable(main_sum_register))
		else $error("OR to memory disturbed the sum register.");

	AST_OR_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
		or_exec |=> test_flag == ($past(or_res) == RST_WORD))
		else $error("Test flag does not match the OR result.");

	AST_SIGN_SHIFT_STEP_SHIFT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_shift_iter |=> main_sum_register == {$past(main_sum_register[ACC_W-2:0]), 1'b0}
		&& !test_flag)
		else $error("Shift step did not shift or clear the flag.");

	AST_ZERO_STOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sign_shift_step_exec && main_sum_register == RST_ACC && !bus_wr)
		|=> test_flag && main_sum_register == RST_ACC && sign_shift_step_stop)
		else $error("Zero sum register was not handled.");

	AST_INC_DEFAULT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_shift_iter and (cur_mode == IND_INC)) |=> cur_ar == DW'($past(cur_ar) + 16'h0001))
		else $error("Default index modification is not an increment.");
endmodule

// ---- testbench/naotm_bench.sv ----
// Self-checking testbench of the normalize and OR-to-memory datapath.
`timescale 1ns/10ps
module naotm_bench
	import naotm_pkg::*;
;
	localparam int P = 2;
	logic              sys_clk;
	logic              rst_n;
	logic [BUS_AW-1:0] bus_addr;
	logic [BUS_DW-1:0] bus_wdata;
	logic              bus_wr;
	logic              bus_rd;
	logic [BUS_DW-1:0] bus_rdata;
	logic              ins_valid;
	logic [1:0]        ins_op;
	logic [1:0]        ins_mode;
	logic              ins_indirect;
	logic [DW-1:0]     ins_dma;
	logic [DW-1:0]     ins_const;
	logic              ins_ext;
	logic [RPT_W-1:0]  ins_rpt;
	logic              ins_ready;
	logic              ins_done;
	logic [1:0]        pc_step;
	logic              test_flag;
	int                n_fail;
	int                n_tests;

	naotm_core #(.PROG_WAIT(P)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ins_valid(ins_valid),
		.ins_op(ins_op), .ins_mode(ins_mode), .ins_indirect(ins_indirect),
		.ins_dma(ins_dma), .ins_const(ins_const), .ins_ext(ins_ext), .ins_rpt(ins_rpt),
		.ins_ready(ins_ready), .ins_done(ins_done), .pc_step(pc_step),
		.test_flag(test_flag)
	);

	// ------------------------------------------------------------------
	// Clock, reset and watchdog
	// ------------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		n_fail++;
		wrap_up();
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cyc(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			n_fail++;
			$display("ERROR at %0t: cycles %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge sys_clk);
		bus_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge sys_clk);
		bus_rd   <= 1'b0;
		#1;
		chk_val(bus_rdata, exp);
	endtask

	// Offers one instruction, counts edges to completion and checks the flag.
	task automatic issue(input logic [1:0] op, input logic [1:0] mode, input logic ind,
			input logic [15:0] dma, input logic [15:0] cst, input logic ext,
			input logic [7:0] single_repeat, input int t_exp, input logic [1:0] step, input logic tf);
		int k;
		@(posedge sys_clk);
		ins_op       <= op;
		ins_mode     <= mode;
		ins_indirect <= ind;
		ins_dma      <= dma;
		ins_const    <= cst;
		ins_ext      <= ext;
		ins_rpt      <= single_repeat;
		ins_valid    <= 1'b1;
		@(posedge sys_clk);
		ins_valid    <= 1'b0;
		k = 0;
		do begin
			@(posedge sys_clk);
			#1;
			k++;
			if (ins_done !== 1'b1) begin
				chk_val({31'h0, ins_ready}, 32'h0);
			end
		end while (ins_done !== 1'b1 && k < 400);
		chk_cyc(k, t_exp);
		chk_val({31'h0, ins_ready}, 32'h1);
		chk_val({30'h0, pc_step}, {30'h0, step});
		chk_val({31'h0, test_flag}, {31'h0, tf});
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic s_reset();
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0C, 32'h0);
		wr(8'h84, 32'h1234);
		rd(8'h84, 32'h0);
	endtask

	task automatic s_shift_one();
		wr(8'h00, 32'h2);
		wr(8'h28, 32'h0);
		wr(8'h08, 32'hFFFF_F001);
		issue(OP_SIGN_SHIFT_STEP, IND_INC, 1'b1, 16'h0, 16'h0, 1'b0, 8'h01, 1, 2'h1, 1'b0);
		rd(8'h08, 32'hFFFF_E002);
		rd(8'h28, 32'h1);
	endtask

	task automatic s_shift_ext_plain();
		issue(OP_SIGN_SHIFT_STEP, IND_PLAIN, 1'b1, 16'h0, 16'h0, 1'b1, 8'h01, 1 + P, 2'h1, 1'b0);
		rd(8'h08, 32'hFFFF_C004);
		rd(8'h28, 32'h1);
	endtask

	task automatic s_repeat_stop();
		wr(8'h08, 32'h1000_0000);
		wr(8'h28, 32'h5);
		issue(OP_SIGN_SHIFT_STEP, IND_DEC, 1'b1, 16'h0, 16'h0, 1'b0, 8'h05, 5, 2'h1, 1'b1);
		rd(8'h08, 32'h4000_0000);
		rd(8'h28, 32'h3);
		rd(8'h0C, 32'h5);
	endtask

	task automatic s_repeat_ext();
		wr(8'h08, 32'hC000_0000);
		issue(OP_SIGN_SHIFT_STEP, IND_INC, 1'b1, 16'h0, 16'h0, 1'b1, 8'h03, 3 + P, 2'h1, 1'b1);
		rd(8'h08, 32'h8000_0000);
		rd(8'h28, 32'h4);
		rd(8'h10, 32'h5);
	endtask

	task automatic s_zero();
		wr(8'h08, 32'h0);
		issue(OP_SIGN_SHIFT_STEP, IND_INC, 1'b1, 16'h0, 16'h0, 1'b0, 8'h03, 3, 2'h1, 1'b1);
		rd(8'h08, 32'h0);
		rd(8'h28, 32'h4);
	endtask

	task automatic s_or_mask();
		wr(8'h08, 32'h1234_5678);
		wr(8'h04, 32'hFFF0);
		wr(8'h54, 32'h0001);
		issue(OP_OR_MASK, IND_PLAIN, 1'b0, 16'h5, 16'h0, 1'b0, 8'h0, 1, 2'h1, 1'b0);
		rd(8'h54, 32'hFFF1);
		rd(8'h08, 32'h1234_5678);
	endtask

	task automatic s_or_const();
		wr(8'h00, 32'h6);
		wr(8'h38, 32'h6);
		wr(8'h58, 32'h000E);
		issue(OP_OR_CONST, IND_PLAIN, 1'b1, 16'h0, 16'h1111, 1'b1, 8'h0, 2 + 2 * P, 2'h2,
			1'b0);
		rd(8'h58, 32'h111F);
		rd(8'h38, 32'h6);
		issue(OP_OR_MASK, IND_INC, 1'b1, 16'h0, 16'h0, 1'b0, 8'h0, 1, 2'h1, 1'b0);
		rd(8'h58, 32'hFFFF);
		rd(8'h38, 32'h7);
	endtask

	task automatic s_or_zero();
		wr(8'h5C, 32'h0);
		issue(OP_OR_CONST, IND_INC, 1'b0, 16'h7, 16'h0, 1'b0, 8'h0, 2, 2'h2, 1'b1);
		rd(8'h5C, 32'h0);
		rd(8'h08, 32'h1234_5678);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		n_fail       = 0;
		n_tests      = 0;
		rst_n        = 1'b0;
		bus_addr     = 8'h00;
		bus_wdata    = 32'h0;
		bus_wr       = 1'b0;
		bus_rd       = 1'b0;
		ins_valid    = 1'b0;
		ins_op       = 2'h0;
		ins_mode     = 2'h0;
		ins_indirect = 1'b0;
		ins_dma      = 16'h0;
		ins_const    = 16'h0;
		ins_ext      = 1'b0;
		ins_rpt      = 8'h0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		s_reset();
		s_shift_one();
		s_shift_ext_plain();
		s_repeat_stop();
		s_repeat_ext();
		s_zero();
		s_or_mask();
		s_or_const();
		s_or_zero();
		wrap_up();
	end
endmodule
